// [rtl/sli_pkg.sv]
package sli_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_COND = 12'h004;
	localparam logic [11:0] ADDR_ALMCNT = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_PRIO = 12'h010;

	// ****************************************************************
	// Field positions of the condition and control registers
	// ****************************************************************
	localparam int COND_PWR = 0;
	localparam int COND_ALARM = 1;
	localparam int COND_ALARM_HARD = 2;
	localparam int COND_REMOVAL = 3;
	localparam int COND_INFO = 4;
	localparam int COND_TEACH = 5;
	localparam int COND_HOMEFN = 6;
	localparam int COND_NOIP = 7;
	localparam int COND_BADCFG = 8;
	localparam int COND_DUPIP = 9;
	localparam int COND_SELFTEST = 10;
	localparam int COND_ONLINE = 11;
	localparam int COND_CONN = 12;
	localparam int COND_TIMEOUT = 13;
	localparam int COND_TRAFFIC = 14;
	localparam int COND_SIM = 15;
	localparam int CTRL_INTERLOCK = 0;
	localparam int CTRL_CLEAR = 1;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [31:0] COND_RESET = 32'h0000_0001;
	localparam logic [31:0] ALMCNT_RESET = 32'h0000_0003;
	localparam logic [31:0] PRIO_RESET = 32'h0000_0000;
	localparam int CLK_HZ = 25_000_000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
	localparam int INTERLOCK_MS = 5000;
	localparam int INTERLOCK_CYCLES = CLK_HZ / 1000 * INTERLOCK_MS;
	localparam int BURST_GAP_PHASES = 4;

	typedef enum {PA_GREEN, PA_ALARM, PA_REMOVAL, PA_REM_WAIT, PA_DOUBLE,
		PA_INTERLOCK, PA_HOMEFN, PA_SIM, PA_OFF} sli_pa_e;

	typedef struct packed {
		logic green;
		logic red;
	} sli_led_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sli_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sli_apb_rsp_s;

endpackage

// [rtl/sli_blink_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module sli_blink_gen
	import sli_pkg::*;
#(
	parameter int PERIOD = BLINK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	output logic tick,
	output logic phase
);
	if (PERIOD < 1) begin
		$error("PERIOD must be at least one cycle.");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
		logic phase;
	} sli_bg_s;

	sli_bg_s st_q;
	sli_bg_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt >= 32'(PERIOD - 1)) begin
			st_d.cnt = 32'h0000_0000;
			st_d.tick = 1'b1;
			st_d.phase = ~st_q.phase;
		end else begin
			st_d.cnt = st_q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;
	assign phase = st_q.phase;
endmodule
`default_nettype wire

// [rtl/sli_status_led.sv]
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Power only: power-alarm steady green.
// - Alarm: red bursts, count set by the alarm count register for both alarm types.
// - Alarm reset returns steady green.
// - Removal blinks green; clear input restores.
// - Information: double-blink both colours together.
// - Teaching or remote: same double-blink pattern.
// - Interlock release blinks both, timed return.
// - Home function executing: both steady.
// - Simulation cycles green, red, both, off.
// - No IP or bad setting: module green blinks.
// - Normal operation: module steady green.
// - Resettable alarm or duplicate IP: red blinks.
// - Unresettable alarm: module steady red.
// - Self-test alternates colours on module, network.
// - Online unconnected: network green blinks.
// - Connected: network steady green.
// - Connection timeout: network red blinks.
// - Duplicate IP steady red; offline dark.
// - Link dark offline, lit online, blinks traffic.
module sli_status_led
	import sli_pkg::*;
#(
	parameter int BLINK_PERIOD = BLINK_CYCLES,
	parameter int INTERLOCK_TIME = INTERLOCK_CYCLES,
	parameter int GAP_PHASES = BURST_GAP_PHASES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sli_apb_req_s apbReq,
	output sli_apb_rsp_s apbRsp,
	input wire logic removalClearInput,
	output sli_led_s powerAlarmIndicator,
	output sli_led_s moduleStatusIndicator,
	output sli_led_s networkStatusIndicator,
	output logic linkActivityIndicator
);
	if (GAP_PHASES < 1 || GAP_PHASES > 15) begin
		$error("GAP_PHASES out of range.");
	end
	if (INTERLOCK_TIME < 1) begin
		$error("INTERLOCK_TIME must be positive.");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] cond;
		logic [3:0] almCount;
		logic prioDoubleFirst;
		sli_pa_e paState;
		logic [5:0] burstPos;
		logic [31:0] ilkCnt;
		logic [1:0] simStep;
		sli_apb_rsp_s rsp;
		sli_led_s pa;
		sli_led_s ms;
		sli_led_s ns;
		logic la;
	} sli_st_s;

	sli_st_s st_q;
	sli_st_s st_d;
	logic tick;
	logic phase;

	// One shared time base keeps every blinking element in step.
	sli_blink_gen #(
		.PERIOD(BLINK_PERIOD)
	) u_blink (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick(tick),
		.phase(phase)
	);

	function automatic logic isAddr(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction

	logic apbAccess;
	logic apbWrite;
	logic [31:0] c;
	logic doubleReq;
	logic [5:0] burstLen;
	logic burstOn;

	assign apbAccess = apbReq.psel && apbReq.penable && !st_q.rsp.pready;
	assign apbWrite = apbAccess && apbReq.pwrite;
	assign c = st_q.cond;
	assign doubleReq = c[COND_INFO] || c[COND_TEACH];

	always_comb begin
		st_d = st_q;
		st_d.rsp.pready = 1'b0;
		st_d.rsp.pslverr = 1'b0;
		burstLen = 6'h00;
		burstOn = 1'b0;

		// ************************************************************
		// APB slave: one wait state, unmapped addresses answer with an error.
		// ************************************************************
		if (apbAccess) begin
			st_d.rsp.pready = 1'b1;
			st_d.rsp.prdata = 32'h0000_0000;
			if (isAddr(apbReq.paddr, ADDR_COND)) begin
				st_d.rsp.prdata = c;
				if (apbReq.pwrite) begin
					st_d.cond = apbReq.pwdata;
				end
			end else if (isAddr(apbReq.paddr, ADDR_ALMCNT)) begin
				st_d.rsp.prdata = {28'h0000000, st_q.almCount};
				if (apbReq.pwrite) begin
					st_d.almCount = apbReq.pwdata[3:0];
				end
			end else if (isAddr(apbReq.paddr, ADDR_PRIO)) begin
				st_d.rsp.prdata = {31'h0, st_q.prioDoubleFirst};
				if (apbReq.pwrite) begin
					st_d.prioDoubleFirst = apbReq.pwdata[0];
				end
			end else if (isAddr(apbReq.paddr, ADDR_STATUS)) begin
				st_d.rsp.prdata = {16'h0000, 4'(st_q.paState), 2'h0, st_q.la,
					st_q.ns, st_q.ms, st_q.pa, st_q.simStep, 1'b0};
			end else if (isAddr(apbReq.paddr, ADDR_CTRL)) begin
				st_d.rsp.prdata = 32'h0000_0000;
			end else begin
				st_d.rsp.pslverr = 1'b1;
			end
		end

		// ************************************************************
		// Power-alarm sequencing.
		// ************************************************************
		if (tick) begin
			st_d.burstPos = st_q.burstPos + 6'h01;
			st_d.simStep = st_q.simStep + 2'h1;
		end
		if (st_q.paState == PA_ALARM) begin
			burstLen = 6'({2'b00, st_q.almCount} << 1);
		end else begin
			burstLen = 6'h04;
		end
		// Six bits hold the longest burst plus the longest gap, so the wrap test never overflows.
		if (tick && st_q.burstPos >= burstLen + 6'(GAP_PHASES) - 6'h01) begin
			st_d.burstPos = 6'h00;
		end
		burstOn = (st_q.burstPos < burstLen) && !st_q.burstPos[0];

		if (st_q.ilkCnt != 32'h0000_0000) begin
			st_d.ilkCnt = st_q.ilkCnt - 32'h0000_0001;
		end
		if (apbWrite && isAddr(apbReq.paddr, ADDR_CTRL) && apbReq.pwdata[CTRL_INTERLOCK]) begin
			st_d.ilkCnt = 32'(INTERLOCK_TIME);
		end

		if (!c[COND_PWR]) begin
			st_d.paState = PA_OFF;
		end else if (c[COND_SIM]) begin
			st_d.paState = PA_SIM;
		end else if (c[COND_ALARM] || c[COND_ALARM_HARD]) begin
			st_d.paState = PA_ALARM;
		end else if (c[COND_REMOVAL]) begin
			st_d.paState = PA_REMOVAL;
		end else if (st_q.paState == PA_REMOVAL || st_q.paState == PA_REM_WAIT) begin
			st_d.paState = removalClearInput ? PA_GREEN : PA_REM_WAIT;
		end else if (st_q.prioDoubleFirst && doubleReq) begin
			st_d.paState = PA_DOUBLE;
		end else if (st_q.ilkCnt != 32'h0000_0000) begin
			st_d.paState = PA_INTERLOCK;
		end else if (c[COND_HOMEFN]) begin
			st_d.paState = PA_HOMEFN;
		end else if (doubleReq) begin
			st_d.paState = PA_DOUBLE;
		end else begin
			st_d.paState = PA_GREEN;
		end

		case (st_q.paState)
			PA_GREEN: st_d.pa = '{green: 1'b1, red: 1'b0};
			PA_ALARM: st_d.pa = '{green: 1'b0, red: burstOn};
			PA_REMOVAL: st_d.pa = '{green: phase, red: 1'b0};
			PA_REM_WAIT: st_d.pa = '{green: 1'b0, red: 1'b0};
			PA_DOUBLE: st_d.pa = '{green: burstOn, red: burstOn};
			PA_INTERLOCK: st_d.pa = '{green: phase, red: phase};
			PA_HOMEFN: st_d.pa = '{green: 1'b1, red: 1'b1};
			PA_SIM: st_d.pa = '{green: !st_q.simStep[0],
				red: st_q.simStep == 2'h1 || st_q.simStep == 2'h2};
			PA_OFF: st_d.pa = '{green: 1'b0, red: 1'b0};
			default: st_d.pa = '{green: 1'b0, red: 1'b0};
		endcase

		// ************************************************************
		// Module and network status.
		// ************************************************************
		if (!c[COND_PWR]) begin
			st_d.ms = '{green: 1'b0, red: 1'b0};
		end else if (c[COND_SELFTEST]) begin
			st_d.ms = '{green: phase, red: !phase};
		end else if (c[COND_ALARM_HARD]) begin
			st_d.ms = '{green: 1'b0, red: 1'b1};
		end else if (c[COND_ALARM] || c[COND_DUPIP]) begin
			st_d.ms = '{green: 1'b0, red: phase};
		end else if (c[COND_NOIP] || c[COND_BADCFG]) begin
			st_d.ms = '{green: phase, red: 1'b0};
		end else begin
			st_d.ms = '{green: 1'b1, red: 1'b0};
		end

		if (!c[COND_PWR]) begin
			st_d.ns = '{green: 1'b0, red: 1'b0};
		end else if (c[COND_SELFTEST]) begin
			st_d.ns = '{green: phase, red: !phase};
		end else if (c[COND_DUPIP]) begin
			st_d.ns = '{green: 1'b0, red: 1'b1};
		end else if (!c[COND_ONLINE]) begin
			st_d.ns = '{green: 1'b0, red: 1'b0};
		end else if (c[COND_TIMEOUT]) begin
			st_d.ns = '{green: 1'b0, red: phase};
		end else if (c[COND_CONN]) begin
			st_d.ns = '{green: 1'b1, red: 1'b0};
		end else begin
			st_d.ns = '{green: phase, red: 1'b0};
		end

		if (!c[COND_PWR] || !c[COND_ONLINE]) begin
			st_d.la = 1'b0;
		end else if (c[COND_TRAFFIC]) begin
			st_d.la = phase;
		end else begin
			st_d.la = 1'b1;
		end

		// The clear strobe drops the software-cleared events in one write.
		if (apbWrite && isAddr(apbReq.paddr, ADDR_CTRL) && apbReq.pwdata[CTRL_CLEAR]) begin
			st_d.cond[COND_ALARM] = 1'b0;
			st_d.cond[COND_INFO] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.cond <= COND_RESET;
			st_q.almCount <= ALMCNT_RESET[3:0];
			st_q.prioDoubleFirst <= PRIO_RESET[0];
			st_q.paState <= PA_GREEN;
		end else begin
			st_q <= st_d;
		end
	end

	assign apbRsp = st_q.rsp;
	assign powerAlarmIndicator = st_q.pa;
	assign moduleStatusIndicator = st_q.ms;
	assign networkStatusIndicator = st_q.ns;
	assign linkActivityIndicator = st_q.la;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_green_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && st_q.paState == PA_GREEN
		|=> powerAlarmIndicator == sli_led_s'{green: 1'b1, red: 1'b0})
		else $error("Idle power indicator not steady green.");
	a_alarm_green_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_ALARM |=> !powerAlarmIndicator.green)
		else $error("Green lit during alarm.");
	a_removal_red_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_REMOVAL |=> !powerAlarmIndicator.red)
		else $error("Red lit during power removal.");
	a_home_both_lit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_HOMEFN |=> powerAlarmIndicator.green && powerAlarmIndicator.red)
		else $error("Home function not showing both colours.");
	a_hard_alarm_red: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && c[COND_ALARM_HARD] && $stable(c)
		|=> moduleStatusIndicator == sli_led_s'{green: 1'b0, red: 1'b1})
		else $error("Unresettable alarm not steady red.");
	a_selftest_alternate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && c[COND_SELFTEST] |=> moduleStatusIndicator.green != moduleStatusIndicator.red)
		else $error("Self-test colours not alternating.");
	a_offline_ns_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!c[COND_ONLINE] && !c[COND_DUPIP] && !c[COND_SELFTEST] && $stable(c)
		|=> networkStatusIndicator == sli_led_s'{green: 1'b0, red: 1'b0})
		else $error("Network indicator lit while offline.");
	a_link_online_lit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && c[COND_ONLINE] && !c[COND_TRAFFIC] && $stable(c) |=> linkActivityIndicator)
		else $error("Link indicator dark while online and idle.");
	a_double_together: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_DOUBLE |=> powerAlarmIndicator.green == powerAlarmIndicator.red)
		else $error("Double blink colours not together.");
	a_interlock_together: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_INTERLOCK |=> powerAlarmIndicator.green == powerAlarmIndicator.red)
		else $error("Interlock blink colours not together.");
	a_removal_wait_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_REM_WAIT |=> !powerAlarmIndicator.green)
		else $error("Green lit before the removal clear input.");

	// The simulation walk must follow green, red, both, dark in that order.
	a_sim_green_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_SIM && st_q.simStep == 2'h0
		|=> powerAlarmIndicator == sli_led_s'{green: 1'b1, red: 1'b0})
		else $error("Simulation step zero not green only.");
	a_sim_red_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_SIM && st_q.simStep == 2'h1
		|=> powerAlarmIndicator == sli_led_s'{green: 1'b0, red: 1'b1})
		else $error("Simulation step one not red only.");
	a_sim_both_lit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_SIM && st_q.simStep == 2'h2
		|=> powerAlarmIndicator == sli_led_s'{green: 1'b1, red: 1'b1})
		else $error("Simulation step two not both lit.");
	a_sim_both_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q.paState == PA_SIM && st_q.simStep == 2'h3
		|=> powerAlarmIndicator == sli_led_s'{green: 1'b0, red: 1'b0})
		else $error("Simulation step three not dark.");

	// Module and network lamps follow the condition word one edge later.
	a_ms_setting_blink: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_ALARM_HARD] && !c[COND_ALARM]
		&& !c[COND_DUPIP] && (c[COND_NOIP] || c[COND_BADCFG])
		|=> !moduleStatusIndicator.red)
		else $error("Module red lit for a setting problem.");
	a_ms_normal_green: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rst_n && c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_ALARM_HARD] && !c[COND_ALARM]
		&& !c[COND_DUPIP] && !c[COND_NOIP] && !c[COND_BADCFG]
		|=> moduleStatusIndicator == sli_led_s'{green: 1'b1, red: 1'b0})
		else $error("Module indicator not steady green in normal operation.");
	a_ms_alarm_blink: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_ALARM_HARD] && (c[COND_ALARM] || c[COND_DUPIP])
		|=> !moduleStatusIndicator.green)
		else $error("Module green lit during a resettable fault.");
	a_ns_waiting_green: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_DUPIP] && c[COND_ONLINE]
		&& !c[COND_TIMEOUT] && !c[COND_CONN]
		|=> !networkStatusIndicator.red)
		else $error("Network red lit while waiting for a connection.");
	a_ns_connected_green: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_DUPIP] && c[COND_ONLINE]
		&& !c[COND_TIMEOUT] && c[COND_CONN]
		|=> networkStatusIndicator == sli_led_s'{green: 1'b1, red: 1'b0})
		else $error("Network indicator not steady green while connected.");
	a_ns_timeout_red: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && !c[COND_DUPIP] && c[COND_ONLINE]
		&& c[COND_TIMEOUT]
		|=> !networkStatusIndicator.green)
		else $error("Network green lit after a connection timeout.");
	a_ns_duplicate_red: assert property (@(posedge sys_clk) disable iff (!rst_n)
		c[COND_PWR] && !c[COND_SELFTEST] && c[COND_DUPIP]
		|=> networkStatusIndicator == sli_led_s'{green: 1'b0, red: 1'b1})
		else $error("Network indicator not steady red on a duplicate address.");
	a_link_offline_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!c[COND_ONLINE] |=> !linkActivityIndicator)
		else $error("Link indicator lit while offline.");
endmodule
`default_nettype wire

// [verification/sli_led_observer.sv]
`timescale 1ns/10ps
`default_nettype none
module sli_led_observer (
	input wire logic sys_clk,
	input wire logic watch,
	input wire logic [6:0] leds,
	output logic [6:0] seen0,
	output logic [6:0] seen1,
	output logic [6:0] seenX
);
	// ****************************************************************
	// Operator view of the lamps
	// ****************************************************************
	// An operator judges a lamp over a window only: dark, lit or blinking.
	// Unknown levels are kept apart so that they never pass for dark.
	always @(posedge sys_clk) begin
		if (!watch) begin
			seen0 <= '0;
			seen1 <= '0;
			seenX <= '0;
		end else begin
			for (int i = 0; i < 7; i++) begin
				if (leds[i] === 1'b1) begin
					seen1[i] <= 1'b1;
				end else if (leds[i] === 1'b0) begin
					seen0[i] <= 1'b1;
				end else begin
					seenX[i] <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [verification/sli_status_led_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module sli_status_led_bench;
	import sli_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	sli_apb_req_s apbReq = '0;
	sli_apb_rsp_s apbRsp;
	logic removalClearInput = 1'b0;
	sli_led_s pa, ms, ns;
	logic la;
	logic watch = 1'b0;
	logic [6:0] seen0, seen1, seenX;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;

	always #20 sys_clk = ~sys_clk;

	sli_status_led #(.BLINK_PERIOD(4), .INTERLOCK_TIME(50), .GAP_PHASES(4)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
		.removalClearInput(removalClearInput), .powerAlarmIndicator(pa),
		.moduleStatusIndicator(ms), .networkStatusIndicator(ns),
		.linkActivityIndicator(la));

	sli_led_observer panel (.sys_clk(sys_clk), .watch(watch),
		.leds({pa.green, pa.red, ms.green, ms.red, ns.green, ns.red, la}),
		.seen0(seen0), .seen1(seen1), .seenX(seenX));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		check({31'h0, apbRsp.pready}, 32'h1, "pready");
		r = apbRsp.prdata;
		e = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp, "read data");
		check({31'h0, e}, {31'h0, expErr}, "slave error");
	endtask

	// Lamps in order pa green, pa red, ms green, ms red, ns green, ns red, link.
	// Codes: 0 dark, 1 lit, b blinking, x not judged.
	task look(input int n, input string s);
		logic [7:0] g;
		@(posedge sys_clk);
		watch <= 1'b1;
		repeat (n) @(posedge sys_clk);
		watch <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			g = seenX[6-i] ? "?" : (seen0[6-i] && seen1[6-i]) ? "b" : seen1[6-i] ? "1" : "0";
			if (s[i] != "x") begin
				check({24'h0, g}, {24'h0, s[i]}, "lamp");
			end
		end
	endtask

	// Conditions reach the power-alarm lamps two edges after the write lands, the other lamps one edge after.
	task cond(input logic [31:0] v, input int n, input string s);
		wr(ADDR_COND, v);
		repeat (3) @(posedge sys_clk);
		look(n, s);
	endtask

	// A window of whole burst periods holds a fixed number of red rising edges.
	task count_red(input int n, input int exp);
		int rises;
		logic prev;
		rises = 0;
		@(posedge sys_clk);
		prev = pa.red;
		repeat (n) begin
			@(posedge sys_clk);
			if (pa.red === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = pa.red;
		end
		check(rises, exp, "red blinks per burst");
	endtask

	task sim_order(input int n);
		logic [1:0] prev;
		logic [1:0] now;
		logic [1:0] want;
		int steps;
		steps = 0;
		@(posedge sys_clk);
		prev = {pa.green, pa.red};
		repeat (n) begin
			@(posedge sys_clk);
			now = {pa.green, pa.red};
			if (now !== prev) begin
				want = prev == 2'h2 ? 2'h1 : prev == 2'h1 ? 2'h3 : prev == 2'h3 ? 2'h0 : 2'h2;
				steps++;
				check({30'h0, now}, {30'h0, want}, "simulation order");
			end
			prev = now;
		end
		check({31'h0, steps >= 4}, 32'h1, "simulation steps");
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task scen_regs;
		look(20, "1010000");
		rdchk(ADDR_COND, COND_RESET, 1'b0);
		rdchk(ADDR_ALMCNT, ALMCNT_RESET, 1'b0);
		rdchk(ADDR_PRIO, PRIO_RESET, 1'b0);
		rdchk(12'h014, 32'h0, 1'b1);
		wr(ADDR_ALMCNT, 32'h0000_0002);
		rdchk(ADDR_ALMCNT, 32'h0000_0002, 1'b0);
	endtask

	task scen_alarm;
		cond(32'h0000_0003, 64, "0b0b000");
		count_red(64, 4);
		wr(ADDR_ALMCNT, 32'h0000_0003);
		count_red(80, 6);
		wr(ADDR_CTRL, 32'h0000_0002);
		repeat (3) @(posedge sys_clk);
		look(16, "1010000");
		cond(32'h0000_0005, 64, "xx01000");
	endtask

	task scen_removal;
		cond(32'h0000_0009, 32, "b0xx000");
		cond(32'h0000_0001, 16, "00xx000");
		@(posedge sys_clk);
		removalClearInput <= 1'b1;
		@(posedge sys_clk);
		removalClearInput <= 1'b0;
		repeat (3) @(posedge sys_clk);
		look(16, "10xx000");
	endtask

	task scen_double;
		cond(32'h0000_0011, 48, "bbxx000");
		count_red(64, 4);
		wr(ADDR_CTRL, 32'h0000_0002);
		repeat (3) @(posedge sys_clk);
		look(16, "10xx000");
		cond(32'h0000_0021, 48, "bbxx000");
		cond(32'h0000_0001, 16, "10xx000");
		cond(32'h0000_0041, 16, "11xx000");
		cond(32'h0000_0001, 16, "10xx000");
		wr(ADDR_PRIO, 32'h0000_0001);
		cond(32'h0000_0051, 48, "bbxx000");
		wr(ADDR_PRIO, 32'h0000_0000);
		cond(32'h0000_0051, 16, "11xx000");
		cond(32'h0000_8001, 32, "bbxxxxx");
		sim_order(40);
	endtask

	task scen_interlock;
		cond(32'h0000_0001, 8, "10xx000");
		wr(ADDR_CTRL, 32'h0000_0001);
		look(30, "bbxx000");
		repeat (40) @(posedge sys_clk);
		look(16, "10xx000");
	endtask

	task scen_network;
		cond(32'h0000_0081, 32, "xxb0000");
		cond(32'h0000_0101, 32, "xxb0000");
		cond(32'h0000_0201, 32, "xx0b010");
		cond(32'h0000_0401, 32, "xxbbbb0");
		cond(32'h0000_0801, 32, "xx10b01");
		cond(32'h0000_1801, 32, "xx10101");
		cond(32'h0000_2801, 32, "xx100b1");
		cond(32'h0000_4801, 32, "xx10b0b");
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict;
		end
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		scen_regs;
		scen_alarm;
		scen_removal;
		scen_double;
		scen_interlock;
		scen_network;
		print_verdict;
	end
endmodule
`default_nettype wire
